/* File: logic/annp_regs.sv */
// annp_regs: expansion, next-page transmit and partner next-page registers.
// assumes the negotiation engine drives its inputs on i_sys_clk; the
// partner status levels come from the line side and are synchronised here.
`timescale 1ns/100ps
module annp_regs (
   input wire logic i_sys_clk, // 250 mhz system clock
   input wire logic i_arst_n, // async reset, active low
   input wire annp_pkg::annp_req_s i_req, // register port request
   output logic [15:0] o_rdata, // read data, cycle after read
   input wire logic i_fault_det, // parallel detection fault level (pin)
   input wire logic i_partner_np, // partner next-page able level (pin)
   input wire logic i_partner_an, // partner autoneg able level (pin)
   input wire logic i_page_rx, // page received pulse, same clock
   input wire annp_pkg::annp_word_s i_rx_word, // received code word
   input wire logic i_page_sent, // next page sent pulse, same clock
   input wire logic i_base_tog, // last base-page toggle value
   input wire logic i_base_done, // base page exchange done pulse
   output annp_pkg::annp_word_s o_tx_word, // code word to send
   output logic o_irq // level interrupt
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [2:0] sync1_r, sync2_r;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end else begin
         sync1_r <= {i_fault_det, i_partner_np, i_partner_an};
         sync2_r <= sync1_r;
      end
   end
   wire logic fault_s = sync2_r[2];
   wire logic pnp_s = sync2_r[1];
   wire logic pan_s = sync2_r[0];

   // ****************************************
   // decode
   // ****************************************
   function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
      return a == b;
   endfunction
   wire logic rd_exp = i_req.rd && hit(i_req.addr, annp_pkg::ADDR_EXPANSION);
   wire logic wr_tx = i_req.wr && hit(i_req.addr, annp_pkg::ADDR_TX_WORD);
   wire logic wr_ctl = i_req.wr && hit(i_req.addr, annp_pkg::ADDR_TX_CTRL);
   wire logic wr_ist = i_req.wr && hit(i_req.addr, annp_pkg::ADDR_IRQ_STATUS);
   wire logic wr_imk = i_req.wr && hit(i_req.addr, annp_pkg::ADDR_IRQ_MASK);

   // ****************************************
   // expansion status state
   // ****************************************
   logic fault_r, fault_nxt, pgrx_r, pgrx_nxt, pnp_r, pan_r;
   // set wins over the read-clear so a fault in the read cycle survives
   assign fault_nxt = fault_s | (fault_r & ~rd_exp);
   // page flag cleared by reading, new page wins
   assign pgrx_nxt = i_page_rx | (pgrx_r & ~rd_exp);
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fault_r <= 1'b0;
         pgrx_r <= 1'b0;
         pnp_r <= 1'b0;
         pan_r <= 1'b0;
      end else begin
         fault_r <= fault_nxt;
         pgrx_r <= pgrx_nxt;
         pnp_r <= pnp_s;
         pan_r <= pan_s;
      end
   end
   wire logic [15:0] exp_word = {11'h000, fault_r, pnp_r, 1'b1, pgrx_r,
      pan_r}; // reserved 15:5 read zero

   // ****************************************
   // transmit word
   // ****************************************
   logic np_r, msg_r, ack2_r, tog_r, tog_nxt;
   logic [10:0] fld_r;
   // toggle starts opposite base page, flips per sent page
   assign tog_nxt = i_base_done ? ~i_base_tog :
      (i_page_sent ? ~tog_r : tog_r);
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         msg_r <= 1'b1;
         ack2_r <= 1'b0;
         fld_r <= annp_pkg::FIELD_RESET;
         np_r <= 1'b0;
         tog_r <= 1'b0;
      end else begin
         if (wr_tx) begin
            msg_r <= i_req.wdata[annp_pkg::BIT_MSG];
            ack2_r <= i_req.wdata[annp_pkg::BIT_ACK2];
            fld_r <= i_req.wdata[10:0];
         end
         // next-page flag is read-only at 0x7, set via control word
         if (wr_ctl)
            np_r <= i_req.wdata[annp_pkg::BIT_NP];
         tog_r <= tog_nxt;
      end
   end
   wire logic [15:0] tx_word = {np_r, 1'b0, msg_r, ack2_r, tog_r,
      fld_r}; // bit 14 zero

   // ****************************************
   // received word
   // ****************************************
   logic [15:0] rx_r;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         rx_r <= annp_pkg::RX_RESET;
      else if (i_page_rx)
         rx_r <= i_rx_word;
   end

   // ****************************************
   // interrupts
   // ****************************************
   logic [annp_pkg::NUM_EV-1:0] ist_r, ist_nxt, imk_r;
   wire logic [annp_pkg::NUM_EV-1:0] ev = {i_page_rx, fault_s & ~fault_r};
   // write-one-to-clear, events win
   assign ist_nxt = ev | (ist_r & ~(wr_ist ? i_req.wdata[1:0] : 2'h0));
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ist_r <= 2'h0;
         imk_r <= 2'h0;
         o_irq <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         if (wr_imk)
            imk_r <= i_req.wdata[1:0];
         o_irq <= |(ist_nxt & (wr_imk ? i_req.wdata[1:0] : imk_r));
      end
   end

   // ****************************************
   // read mux and outputs
   // ****************************************
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      unique case (i_req.addr)
         annp_pkg::ADDR_EXPANSION: rd_mux = exp_word;
         annp_pkg::ADDR_TX_WORD: rd_mux = tx_word;
         annp_pkg::ADDR_RX_WORD: rd_mux = rx_r;
         annp_pkg::ADDR_IRQ_STATUS: rd_mux = {14'h0000, ist_r};
         annp_pkg::ADDR_IRQ_MASK: rd_mux = {14'h0000, imk_r};
         annp_pkg::ADDR_TX_CTRL: rd_mux = {np_r, 15'h0000};
         default: rd_mux = 16'h0000;
      endcase
   end
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= 16'h0000;
         o_tx_word <= annp_pkg::WORD_RESET;
      end else begin
         o_rdata <= i_req.rd ? rd_mux : 16'h0000;
         o_tx_word <= {np_r, 1'b0, msg_r, ack2_r, tog_nxt, fld_r};
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   a_fault_hold: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      fault_r && !rd_exp |=> fault_r) else $error("fault dropped");
   a_fault_clear: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      rd_exp && !fault_s |=> !fault_r) else $error("fault kept");
   a_np_able: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      i_req.rd && i_req.addr == annp_pkg::ADDR_EXPANSION |=> o_rdata[2])
      else $error("np able zero");
   a_page_set: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      i_page_rx |=> pgrx_r && rx_r == $past(i_rx_word))
      else $error("page not taken");
   a_pnp_track: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      pnp_s |=> pnp_r) else $error("pnp lag");
   a_pan_track: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !pan_s |=> !pan_r) else $error("pan lag");
   a_tx_rsvd: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !o_tx_word.ack) else $error("bit 14 set");
   a_tog_flip: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      i_page_sent && !i_base_done && !wr_tx |=> tog_r != $past(tog_r))
      else $error("toggle stuck");
   a_msg_write: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      wr_tx |=> msg_r == $past(i_req.wdata[13]) && ack2_r ==
      $past(i_req.wdata[12]) && fld_r == $past(i_req.wdata[10:0]))
      else $error("tx write lost");
   a_np_flag: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      wr_ctl |=> ##2 o_tx_word.np == $past(i_req.wdata[15], 3))
      else $error("np flag");
   c_fault_read: cover property (@(posedge i_sys_clk) fault_r ##1 rd_exp);
   c_page: cover property (@(posedge i_sys_clk) i_page_rx ##[1:4] rd_exp);
   c_irq: cover property (@(posedge i_sys_clk) o_irq ##1 wr_ist);
endmodule

/* File: logic/annp_pkg.sv */
// annp_pkg: constants and carriers of the auto-negotiation next-page bank.
// assumes one system clock domain and a plain one-cycle register port.
// Summary of operation
// - fault bit latches high until register read
// - bit 3 shows partner next-page capability
// - bit 2 always reads one
// - bit 1 set on new received page
// - bit 0 shows partner autoneg ability
// - tx word bit 15 from next-page flag
// - tx bit 14 reserved, reads zero
// - writable message-page flag, resets to one
// - writable acknowledge-2 flag, resets to zero
// - read-only toggle drives tx bit 11
// - writable 11-bit message field, reset 0x001
// - received word flags captured read-only
// - received message field, reset 0x001
package annp_pkg;
   // ****************************************
   // register map and field positions
   // ****************************************
   localparam logic [3:0] ADDR_EXPANSION = 4'h6;
   localparam logic [3:0] ADDR_TX_WORD = 4'h7;
   localparam logic [3:0] ADDR_RX_WORD = 4'h8;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h9;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'ha;
   localparam logic [3:0] ADDR_TX_CTRL = 4'hb;
   localparam int BIT_FAULT = 4;
   localparam int BIT_PNP = 3;
   localparam int BIT_LNP = 2;
   localparam int BIT_PGRX = 1;
   localparam int BIT_PAN = 0;
   localparam int BIT_NP = 15;
   localparam int BIT_ACK = 14;
   localparam int BIT_MSG = 13;
   localparam int BIT_ACK2 = 12;
   localparam int BIT_TOG = 11;
   localparam logic [10:0] FIELD_RESET = 11'h001;
   localparam logic [15:0] WORD_RESET = 16'h2001;
   localparam logic [15:0] RX_RESET = 16'h0001;
   // interrupt events: fault, page received
   localparam int EV_FAULT = 0;
   localparam int EV_PAGE = 1;
   localparam int NUM_EV = 2;

   // code word as it travels on the link
   typedef struct packed {
      logic np;
      logic ack;
      logic msg;
      logic ack2;
      logic tog;
      logic [10:0] field;
   } annp_word_s;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } annp_req_s;
endpackage

/* File: sim/annp_partner.sv */
// annp_partner: link partner model delivering received next pages.
// assumes the bench asks for a page with a one-cycle send request.
`timescale 1ns/100ps
module annp_partner (
   input wire logic i_sys_clk, // system clock
   input wire logic i_send, // deliver a page on the next cycle
   input wire annp_pkg::annp_word_s i_word, // page to deliver
   output logic o_page_rx, // one-cycle page strobe
   output annp_pkg::annp_word_s o_rx_word // word, valid with strobe only
);
   annp_pkg::annp_word_s last_r = '0;
   initial o_page_rx = 1'b0;
   initial o_rx_word = '0;
   // outside the strobe the word is junk, so a late capture shows up
   always @(posedge i_sys_clk) begin
      o_page_rx <= i_send;
      o_rx_word <= i_send ? i_word : ~last_r;
      if (i_send) last_r <= i_word;
   end
endmodule

/* File: sim/annp_regs_bench.sv */
// annp_regs_bench: self-checking bench for the next-page register bank.
// assumes the partner model in its own file and no other stimulus.
`timescale 1ns/100ps
module annp_regs_bench;
   // ****
   // stimulus and design
   // ****
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   annp_pkg::annp_req_s req = '0;
   annp_pkg::annp_word_s txw, rxw, word = '0;
   logic [15:0] rdata, d, w;
   logic fault = 1'b0, pnp = 1'b0, pan = 1'b0, send = 1'b0;
   logic sent = 1'b0, btog = 1'b0, bdone = 1'b0, page_rx, irq;
   int errors = 0, checks_done = 0;
   always #2 sys_clk = ~sys_clk;
   annp_partner PARTNER (.i_sys_clk(sys_clk), .i_send(send), .i_word(word),
      .o_page_rx(page_rx), .o_rx_word(rxw));
   annp_regs DUT (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_req(req),
      .o_rdata(rdata), .i_fault_det(fault), .i_partner_np(pnp),
      .i_partner_an(pan), .i_page_rx(page_rx), .i_rx_word(rxw),
      .i_page_sent(sent), .i_base_tog(btog), .i_base_done(bdone),
      .o_tx_word(txw), .o_irq(irq));
   // compare and count
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task wr(input logic [3:0] a, input logic [15:0] v);
      cyc(1); req <= '{a, v, 1'b1, 1'b0};
      cyc(1); req <= '0;
   endtask
   // read data stands only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [15:0] v);
      cyc(1); req <= '{a, 16'h0, 1'b0, 1'b1};
      cyc(1); req <= '0;
      @(negedge sys_clk) v = rdata;
   endtask
   function logic [15:0] ex(input logic f, p, g, n);
      return {11'h0, f, p, 1'b1, g, n};
   endfunction
   function logic [15:0] tx(input logic np, tg, input logic [15:0] v);
      return {np, 1'b0, v[13:12], tg, v[10:0]};
   endfunction
   task end_of_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog: tests need well under a thousand cycles
   initial begin
      #20000;
      errors++;
      end_of_test;
   end
   // main sequence
   initial begin
      void'($urandom(32'hd02e));
      cyc(2); arst_n <= 1'b1;
      rd(4'h6, d); chk(d, ex(0, 0, 0, 0));
      rd(4'h7, d); chk(d, 16'h2001);
      rd(4'h8, d); chk(d, 16'h0001);
      rd(4'hf, d); chk(d, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         w = 16'($urandom);
         wr(4'h7, w); wr(4'h6, 16'hffff);
         rd(4'h7, d); chk(d, tx(0, 0, w));
         chk(txw, tx(0, 0, w));
         cyc(1); send <= 1'b1; word <= ~w;
         cyc(1); send <= 1'b0; cyc(i);
         wr(4'h8, w);
         rd(4'h8, d); chk(d, ~w);
         rd(4'h6, d); chk(d, ex(0, 0, 1, 0));
         rd(4'h6, d); chk(d, ex(0, 0, 0, 0));
      end
      $display("test pages done");
      cyc(1); pnp <= 1'b1; pan <= 1'b1;
      cyc(5); rd(4'h6, d); chk(d, ex(0, 1, 0, 1));
      cyc(1); pnp <= 1'b0;
      cyc(5); rd(4'h6, d); chk(d, ex(0, 0, 0, 1));
      wr(4'h9, 16'h0003); wr(4'ha, 16'h0003);
      cyc(1); fault <= 1'b1;
      cyc(5); fault <= 1'b0;
      cyc(5); chk({15'h0, irq}, 16'h0001);
      rd(4'h6, d); chk(d, ex(1, 0, 0, 1));
      rd(4'h6, d); chk(d, ex(0, 0, 0, 1));
      cyc(1); fault <= 1'b1;
      cyc(5); rd(4'h6, d); rd(4'h6, d); chk(d, ex(1, 0, 0, 1));
      cyc(1); fault <= 1'b0;
      wr(4'h9, 16'h0003); cyc(2); chk({15'h0, irq}, 16'h0000);
      // fault still latched: read it away so the next rise is an event
      rd(4'h6, d); chk(d, ex(1, 0, 0, 1));
      rd(4'h6, d); chk(d, ex(0, 0, 0, 1));
      wr(4'ha, 16'h0000);
      cyc(1); fault <= 1'b1;
      cyc(5); chk({15'h0, irq}, 16'h0000);
      rd(4'h9, d); chk(d, 16'h0001);
      cyc(1); fault <= 1'b0;
      $display("test fault done");
      wr(4'hb, 16'h8000);
      rd(4'h7, d); chk({15'h0, d[15]}, 16'h0001);
      cyc(1); bdone <= 1'b1;
      cyc(1); bdone <= 1'b0;
      rd(4'h7, d); chk({15'h0, d[11]}, 16'h0001);
      for (int i = 0; i < 2; i++) begin
         cyc(1); sent <= 1'b1;
         cyc(1); sent <= 1'b0;
         rd(4'h7, d); chk({15'h0, d[11]}, 16'(i));
         chk({15'h0, txw.tog}, 16'(i));
      end
      $display("test toggle done");
      end_of_test;
   end
endmodule
